// ### src/csfm_pkg.sv
// Package of constants, codes and types for the capacitive sense measurement block.
package csfm_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths of the register port and of the synchroniser bank.
    localparam int unsigned ADDR_W = 4; // Register address width in bits.
    localparam int unsigned DATA_W = 8; // Register data width in bits.
    localparam int unsigned SYNC_N = 4; // Number of pin inputs brought into the clock domain.

    // Positions of the pin inputs inside the synchroniser bank.
    localparam int unsigned SYNC_OSC = 0; // Sensing oscillator comparator output.
    localparam int unsigned SYNC_T0PIN = 1; // Timer0 external clock pin.
    localparam int unsigned SYNC_T1GATE = 2; // Timer1 gate pin.
    localparam int unsigned SYNC_T1PIN = 3; // Timer1 external clock pin.

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets.
    localparam logic [3:0] OFS_SENSE_CTRL = 4'h0; // Sense control register.
    localparam logic [3:0] OFS_TIMER_CFG = 4'h1; // Timer configuration register.
    localparam logic [3:0] OFS_TMR0 = 4'h2; // Timer0 count.
    localparam logic [3:0] OFS_STATUS = 4'h3; // Overflow flag and gate level.
    localparam logic [3:0] OFS_TMR1_LO = 4'h4; // Timer1 count, low byte.
    localparam logic [3:0] OFS_TMR1_HI = 4'h5; // Timer1 count, high byte.

    // Field positions in the sense control register.
    localparam int unsigned BIT_MODULE_EN = 7; // Module enable.
    localparam int unsigned BIT_RANGE_SEL = 6; // Reference range select.
    localparam int unsigned BIT_CUR_LO = 2; // Low bit of the two-bit current range code.
    localparam int unsigned BIT_OSC_STATUS = 1; // Read-only oscillator status.
    localparam int unsigned BIT_T0_EXT_SEL = 0; // Timer0 external select.

    // Field positions in the timer configuration register.
    localparam int unsigned BIT_T0_CLK_SRC = 0; // Timer0 clock source.
    localparam int unsigned BIT_T1_CLK_LO = 1; // Low bit of the two-bit Timer1 clock select.
    localparam int unsigned BIT_T1_ON = 3; // Timer1 on.
    localparam int unsigned BIT_T1_GATE_EN = 4; // Timer1 gate enable.
    localparam int unsigned BIT_T1_GATE_TGL = 5; // Timer1 gate toggle mode.
    localparam int unsigned BIT_T1_GATE_SRC = 6; // Gate source: 0 pin, 1 Timer0 overflow.

    // Field positions in the status register.
    localparam int unsigned BIT_T0_OVF = 0; // Timer0 overflow flag, write one to clear.
    localparam int unsigned BIT_GATE_LVL = 1; // Current Timer1 gate level.

    // Writable bits of the two configuration registers.
    localparam logic [7:0] CTRL_WR_MASK = 8'hCD; // Bits 5, 4 and 1 are not writable.
    localparam logic [7:0] CFG_WR_MASK = 8'h7F; // Bit 7 is reserved.

    // Reset values.
    localparam logic [7:0] RST_SENSE_CTRL = 8'h00; // Module off, low range.
    localparam logic [7:0] RST_TIMER_CFG = 8'h00; // Timer1 off, internal clocks.
    localparam logic [7:0] RST_TMR0 = 8'h00; // Timer0 cleared.
    localparam logic [15:0] RST_TMR1 = 16'h0000; // Timer1 cleared.
    localparam logic [7:0] TMR0_MAX = 8'hFF; // Timer0 value that overflows on the next tick.

    ////////////////////////////////////////////////////////////////////////////////
    // Timer1 clock select codes.
    localparam logic [1:0] T1CLK_INSTR = 2'h0; // Instruction clock.
    localparam logic [1:0] T1CLK_SYS = 2'h1; // System clock.
    localparam logic [1:0] T1CLK_PIN = 2'h2; // External clock pin.
    localparam logic [1:0] T1CLK_OSC = 2'h3; // Sensing oscillator.

    // Current range codes, also the drive level put out to the pad.
    localparam logic [1:0] CUR_OFF = 2'h0; // No drive.
    localparam logic [1:0] CUR_LOW = 2'h1; // Low current.
    localparam logic [1:0] CUR_MED = 2'h2; // Medium current.
    localparam logic [1:0] CUR_HIGH = 2'h3; // High current.

    // The instruction clock is one core cycle in this many.
    localparam int unsigned INSTR_DIV = 4; // Core cycles per instruction cycle.
    localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_DIV - 1); // Last divider count.

    ////////////////////////////////////////////////////////////////////////////////
    // Power modes of the sensing oscillator, one-hot.
    typedef enum logic [7:0] {
        CSFM_MODE_OFF = 8'h01,
        CSFM_MODE_LO_LOW = 8'h02,
        CSFM_MODE_LO_MED = 8'h04,
        CSFM_MODE_LO_HIGH = 8'h08,
        CSFM_MODE_NOISE = 8'h10,
        CSFM_MODE_HI_LOW = 8'h20,
        CSFM_MODE_HI_MED = 8'h40,
        CSFM_MODE_HI_HIGH = 8'h80
    } csfm_mode_t;

endpackage

// ### src/csfm_sync_if.sv
// Interface carrying synchronised pin levels and their rising edges.
`timescale 1ns/100ps
`default_nettype none
interface csfm_sync_if;
    logic [csfm_pkg::SYNC_N-1:0] level; // Synchronised levels.
    logic [csfm_pkg::SYNC_N-1:0] rise; // One-cycle pulse on each rising edge.
    modport src (output level, output rise);
    modport dst (input level, input rise);
endinterface
`default_nettype wire

// ### src/csfm_edge_sync.sv
// Two-flop synchroniser bank with rising edge detection for the pin inputs.
`timescale 1ns/100ps
`default_nettype none
module csfm_edge_sync (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Asynchronous inputs.
    input wire logic [csfm_pkg::SYNC_N-1:0] async_i,
    // Synchronised results.
    csfm_sync_if.src sync_bus
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [csfm_pkg::SYNC_N-1:0] meta_ff; // First stage, read only by the second stage.
    logic [csfm_pkg::SYNC_N-1:0] sync_ff; // Second stage, safe to use.
    logic [csfm_pkg::SYNC_N-1:0] prev_ff; // Second stage delayed, for edge detection.

    // The three stages shift together; only sync_ff and prev_ff feed any logic.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
            prev_ff <= '0;
        end else begin
            meta_ff <= async_i; // see [R16]
            sync_ff <= meta_ff; // see [R16]
            prev_ff <= sync_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Each input yields one pulse per rising edge, so a count is neither lost nor doubled.
    genvar gi;
    generate
        for (gi = 0; gi < csfm_pkg::SYNC_N; gi = gi + 1) begin : g_edge
            assign sync_bus.rise[gi] = sync_ff[gi] & ~prev_ff[gi]; // see [R16]
        end
    endgenerate

    // Levels leave straight from the second stage.
    assign sync_bus.level = sync_ff;

endmodule
`default_nettype wire

// ### src/csfm_top.sv
// Capacitive sense oscillator control, mode decode and oscillator-clocked timers.
//
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [R1] Range bit picks converter/fixed or ground/supply thresholds.
// [R2] Low range code: off, low, medium, high.
// [R3] High range code zero: noise detect, drive off.
// [R4] Noise on the pin still clocks the comparator.
// [R5] External select, clock source clear: oscillator clocks Timer0.
// [R6] Timer1 select code three: oscillator clocks Timer1.
// [R7] Timer1 off, free running, or gated.
// [R8] Time base comes from another resource.
// [R9] Time base from Timer0 overflow and gate toggle.
// [R10] Clear timer at start, capture at end.
// [R11] Frequency is count over time base.
// [R12] Loaded run uses same base, counts lower.
// [R13] Threshold halfway between unloaded and loaded.
// [R14] Oscillator keeps running in sleep while enabled.
// [R15] Timer0 does not count during sleep.
// [R16] Comparator synchronised and edge detected before counting.
module csfm_top (
    // Clock and reset.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // Register port.
    input wire logic [csfm_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [csfm_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [csfm_pkg::DATA_W-1:0] reg_rdata_o,
    // Device state.
    input wire logic sleep_i,
    // Pins and analogue comparator, all asynchronous.
    input wire logic osc_cmp_i,
    input wire logic t0_pin_i,
    input wire logic t1_gate_pin_i,
    input wire logic t1_pin_i,
    // Analogue oscillator controls.
    output logic osc_enable_o,
    output logic current_drive_en_o,
    output logic [1:0] current_level_o,
    output logic noise_detect_o,
    output logic ref_lo_converter_o,
    output logic ref_hi_fixed_reference_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Returns one when a register access hits the given offset.
    function automatic logic csfm_hit(input logic [3:0] addr, input logic [3:0] ofs);
        csfm_hit = (addr == ofs);
    endfunction

    // Maps enable, range select and current code onto a power mode.
    function automatic csfm_pkg::csfm_mode_t csfm_decode(input logic en, input logic rsel,
                                                         input logic [1:0] code);
        csfm_decode = csfm_pkg::CSFM_MODE_OFF;
        if (en && !rsel) begin
            case (code) // see [R2]
                csfm_pkg::CUR_LOW: csfm_decode = csfm_pkg::CSFM_MODE_LO_LOW;
                csfm_pkg::CUR_MED: csfm_decode = csfm_pkg::CSFM_MODE_LO_MED;
                csfm_pkg::CUR_HIGH: csfm_decode = csfm_pkg::CSFM_MODE_LO_HIGH;
                default: csfm_decode = csfm_pkg::CSFM_MODE_OFF;
            endcase
        end else if (en) begin
            case (code)
                csfm_pkg::CUR_LOW: csfm_decode = csfm_pkg::CSFM_MODE_HI_LOW;
                csfm_pkg::CUR_MED: csfm_decode = csfm_pkg::CSFM_MODE_HI_MED;
                csfm_pkg::CUR_HIGH: csfm_decode = csfm_pkg::CSFM_MODE_HI_HIGH;
                default: csfm_decode = csfm_pkg::CSFM_MODE_NOISE; // see [R3]
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers and state.
    logic [7:0] ctrl_ff; // Sense control bits.
    logic [7:0] cfg_ff; // Timer configuration bits.
    logic [7:0] tmr0_ff; // Timer0 count.
    logic [15:0] tmr1_ff; // Timer1 count.
    logic t0_ovf_ff; // Sticky Timer0 overflow flag.
    logic gate_lvl_ff; // Timer1 gate level in effect.
    logic [1:0] div_ff; // Instruction clock divider.
    logic instr_tick_ff; // One-cycle instruction clock enable.
    csfm_pkg::csfm_mode_t nxt_mode; // Power mode decoded from the control bits.
    logic [7:0] rdata_ff; // Read data, valid in the cycle after a read strobe.

    // Decoded strobes and timer events.
    logic wr_ctrl, wr_cfg, wr_tmr0, wr_stat, wr_t1lo, wr_t1hi;
    logic t0_tick; // Timer0 counts this cycle.
    logic t1_clk_tick; // Timer1 clock edge this cycle, before the gate.
    logic t1_tick; // Timer1 counts this cycle.
    logic t0_ovf_pulse; // Timer0 wraps this cycle.
    logic gate_src_lvl; // Level of the chosen gate source.
    logic gate_src_rise; // Rising edge of the chosen gate source.

    // Synchronised pin levels and edges.
    csfm_sync_if sync_bus ();

    csfm_edge_sync u_sync (
        .ref_clk_i (ref_clk_i),
        .srst_i (srst_i),
        .async_i ({t1_pin_i, t1_gate_pin_i, t0_pin_i, osc_cmp_i}),
        .sync_bus (sync_bus)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Write strobe decode.
    assign wr_ctrl = reg_wr_i && csfm_hit(reg_addr_i, csfm_pkg::OFS_SENSE_CTRL);
    assign wr_cfg = reg_wr_i && csfm_hit(reg_addr_i, csfm_pkg::OFS_TIMER_CFG);
    assign wr_tmr0 = reg_wr_i && csfm_hit(reg_addr_i, csfm_pkg::OFS_TMR0);
    assign wr_stat = reg_wr_i && csfm_hit(reg_addr_i, csfm_pkg::OFS_STATUS);
    assign wr_t1lo = reg_wr_i && csfm_hit(reg_addr_i, csfm_pkg::OFS_TMR1_LO);
    assign wr_t1hi = reg_wr_i && csfm_hit(reg_addr_i, csfm_pkg::OFS_TMR1_HI);

    // Control registers keep only their writable bits.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl_ff <= csfm_pkg::RST_SENSE_CTRL;
            cfg_ff <= csfm_pkg::RST_TIMER_CFG;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= reg_wdata_i & csfm_pkg::CTRL_WR_MASK;
            end
            if (wr_cfg) begin
                cfg_ff <= reg_wdata_i & csfm_pkg::CFG_WR_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power mode decode and the analogue controls that follow from it.
    assign nxt_mode = csfm_decode(ctrl_ff[csfm_pkg::BIT_MODULE_EN],
                                  ctrl_ff[csfm_pkg::BIT_RANGE_SEL],
                                  ctrl_ff[csfm_pkg::BIT_CUR_LO +: 2]);

    // Sleep is not an input here: the oscillator runs on while the module is enabled, except at low range code zero.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            osc_enable_o <= 1'b0;
            current_drive_en_o <= 1'b0;
            current_level_o <= csfm_pkg::CUR_OFF;
            noise_detect_o <= 1'b0;
            ref_lo_converter_o <= 1'b0;
            ref_hi_fixed_reference_o <= 1'b0;
        end else begin
            // Threshold sources follow the range bit alone.
            ref_lo_converter_o <= ctrl_ff[csfm_pkg::BIT_RANGE_SEL]; // see [R1]
            ref_hi_fixed_reference_o <= ctrl_ff[csfm_pkg::BIT_RANGE_SEL]; // see [R1]
            case (nxt_mode)
                csfm_pkg::CSFM_MODE_OFF: begin
                    osc_enable_o <= 1'b0;
                    current_drive_en_o <= 1'b0;
                    current_level_o <= csfm_pkg::CUR_OFF;
                    noise_detect_o <= 1'b0;
                end
                csfm_pkg::CSFM_MODE_NOISE: begin
                    // Comparator stays alive, pad drive stops.
                    osc_enable_o <= 1'b1; // see [R3], see [R14]
                    current_drive_en_o <= 1'b0; // see [R3]
                    current_level_o <= csfm_pkg::CUR_OFF;
                    noise_detect_o <= 1'b1;
                end
                default: begin
                    // The other six modes drive the pad at the coded level.
                    osc_enable_o <= 1'b1; // see [R14]
                    current_drive_en_o <= 1'b1; // see [R2]
                    current_level_o <= ctrl_ff[csfm_pkg::BIT_CUR_LO +: 2]; // see [R2]
                    noise_detect_o <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction clock enable: one core cycle in four.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            div_ff <= 2'h0;
            instr_tick_ff <= 1'b0;
        end else begin
            div_ff <= (div_ff == csfm_pkg::INSTR_DIV_LAST) ? 2'h0 : div_ff + 2'h1;
            instr_tick_ff <= (div_ff == csfm_pkg::INSTR_DIV_LAST);
        end
    end

    // Timer0 clock choice; the comparator edge counts in every mode, noise detect too.
    always_comb begin
        if (ctrl_ff[csfm_pkg::BIT_T0_EXT_SEL] && !cfg_ff[csfm_pkg::BIT_T0_CLK_SRC]) begin
            t0_tick = sync_bus.rise[csfm_pkg::SYNC_OSC]; // see [R5], see [R4]
        end else if (cfg_ff[csfm_pkg::BIT_T0_CLK_SRC]) begin
            t0_tick = sync_bus.rise[csfm_pkg::SYNC_T0PIN];
        end else begin
            t0_tick = instr_tick_ff;
        end
        t0_tick = t0_tick && !sleep_i; // see [R15]
    end

    // Timer1 clock choice; the core clocks stop in sleep, the outside ones do not.
    always_comb begin
        case (cfg_ff[csfm_pkg::BIT_T1_CLK_LO +: 2])
            csfm_pkg::T1CLK_INSTR: t1_clk_tick = instr_tick_ff && !sleep_i;
            csfm_pkg::T1CLK_SYS: t1_clk_tick = !sleep_i;
            csfm_pkg::T1CLK_PIN: t1_clk_tick = sync_bus.rise[csfm_pkg::SYNC_T1PIN];
            default: t1_clk_tick = sync_bus.rise[csfm_pkg::SYNC_OSC]; // see [R6], see [R4]
        endcase
    end

    assign t0_ovf_pulse = t0_tick && !wr_tmr0 && (tmr0_ff == csfm_pkg::TMR0_MAX);
    assign gate_src_lvl = cfg_ff[csfm_pkg::BIT_T1_GATE_SRC] ? t0_ovf_ff
                                                            : sync_bus.level[csfm_pkg::SYNC_T1GATE];
    assign gate_src_rise = cfg_ff[csfm_pkg::BIT_T1_GATE_SRC] ? t0_ovf_pulse
                                                             : sync_bus.rise[csfm_pkg::SYNC_T1GATE];
    // Off, free running, or counting only while the gate is open.
    assign t1_tick = t1_clk_tick && cfg_ff[csfm_pkg::BIT_T1_ON] &&
                     (!cfg_ff[csfm_pkg::BIT_T1_GATE_EN] || gate_lvl_ff); // see [R7]

    ////////////////////////////////////////////////////////////////////////////////
    // Timer0 count and sticky overflow flag; a new overflow beats a clear.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tmr0_ff <= csfm_pkg::RST_TMR0;
            t0_ovf_ff <= 1'b0;
        end else begin
            if (wr_tmr0) begin
                tmr0_ff <= reg_wdata_i; // see [R10]
            end else if (t0_tick) begin
                tmr0_ff <= tmr0_ff + 8'h01;
            end
            if (t0_ovf_pulse) begin
                t0_ovf_ff <= 1'b1;
            end else if (wr_stat && reg_wdata_i[csfm_pkg::BIT_T0_OVF]) begin
                t0_ovf_ff <= 1'b0;
            end
        end
    end

    // Gate level: follows the source, or toggles on each source edge in toggle mode.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            gate_lvl_ff <= 1'b0;
        end else if (!cfg_ff[csfm_pkg::BIT_T1_GATE_TGL]) begin
            gate_lvl_ff <= gate_src_lvl;
        end else if (gate_src_rise) begin
            gate_lvl_ff <= !gate_lvl_ff; // see [R9]
        end
    end

    // Timer1 count; a byte write wins over a tick in the same cycle.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tmr1_ff <= csfm_pkg::RST_TMR1;
        end else if (wr_t1lo) begin
            tmr1_ff[7:0] <= reg_wdata_i; // see [R10]
        end else if (wr_t1hi) begin
            tmr1_ff[15:8] <= reg_wdata_i; // see [R10]
        end else if (t1_tick) begin
            tmr1_ff <= tmr1_ff + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data for one cycle after the strobe; unmapped offsets read zero.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !reg_rd_i) begin
            rdata_ff <= 8'h00;
        end else if (csfm_hit(reg_addr_i, csfm_pkg::OFS_SENSE_CTRL)) begin
            rdata_ff <= ctrl_ff | (8'(sync_bus.level[csfm_pkg::SYNC_OSC])
                                   << csfm_pkg::BIT_OSC_STATUS);
        end else if (csfm_hit(reg_addr_i, csfm_pkg::OFS_TIMER_CFG)) begin
            rdata_ff <= cfg_ff;
        end else if (csfm_hit(reg_addr_i, csfm_pkg::OFS_TMR0)) begin
            rdata_ff <= tmr0_ff;
        end else if (csfm_hit(reg_addr_i, csfm_pkg::OFS_STATUS)) begin
            rdata_ff <= (8'(t0_ovf_ff) << csfm_pkg::BIT_T0_OVF) |
                        (8'(gate_lvl_ff) << csfm_pkg::BIT_GATE_LVL);
        end else if (csfm_hit(reg_addr_i, csfm_pkg::OFS_TMR1_LO)) begin
            rdata_ff <= tmr1_ff[7:0];
        end else if (csfm_hit(reg_addr_i, csfm_pkg::OFS_TMR1_HI)) begin
            rdata_ff <= tmr1_ff[15:8];
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata_o = rdata_ff;

endmodule
`default_nettype wire

// ### verif/csfm_top_sva.sv
// Checker for the sense control decode and the register read port.
`timescale 1ns/100ps
`default_nettype none
module csfm_top_sva (
    // Clock, reset and register port.
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [csfm_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [csfm_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [csfm_pkg::DATA_W-1:0] reg_rdata_o,
    // Analogue controls.
    input wire logic osc_enable_o,
    input wire logic current_drive_en_o,
    input wire logic [1:0] current_level_o,
    input wire logic noise_detect_o,
    input wire logic ref_lo_converter_o,
    input wire logic ref_hi_fixed_reference_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // Shadow of the sense control register, kept from the writes seen.
    logic [7:0] ctrl_ff;
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl_ff <= 8'h00;
        end else if (reg_wr_i && reg_addr_i == csfm_pkg::OFS_SENSE_CTRL) begin
            ctrl_ff <= reg_wdata_i & csfm_pkg::CTRL_WR_MASK;
        end
    end
    // A read of the control register taken at this edge.
    sequence ctrl_rd_s;
        reg_rd_i && reg_addr_i == csfm_pkg::OFS_SENSE_CTRL;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    ref_lo_sel_a: assert property (1'b1 |=> ref_lo_converter_o == $past(ctrl_ff[6]))
        else $error("lower threshold source wrong");
    ref_hi_sel_a: assert property (1'b1 |=>
        ref_hi_fixed_reference_o == $past(ctrl_ff[6]))
        else $error("upper threshold source wrong");
    low_off_a: assert property (ctrl_ff[7:6] == 2'b10 && ctrl_ff[3:2] == 2'h0 |=>
        !osc_enable_o) else $error("oscillator on in low range off code");
    drive_level_a: assert property (ctrl_ff[7] && ctrl_ff[3:2] != 2'h0 |=>
        osc_enable_o && current_drive_en_o && current_level_o == $past(ctrl_ff[3:2]))
        else $error("drive wrong");
    noise_mode_a: assert property (ctrl_ff[7:6] == 2'b11 && ctrl_ff[3:2] == 2'h0 |=>
        noise_detect_o && osc_enable_o && !current_drive_en_o) else $error("noise mode wrong");
    module_off_a: assert property (!ctrl_ff[7] |=>
        !osc_enable_o && !current_drive_en_o) else $error("oscillator on while module disabled");
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data not zero outside read answer");
    ctrl_back_a: assert property (ctrl_rd_s |=> {reg_rdata_o[7:2], reg_rdata_o[0]} ==
        $past({ctrl_ff[7:2], ctrl_ff[0]})) else $error("control readback wrong");
endmodule
`default_nettype wire

// ### verif/csfm_pad_model.sv
// Model of the sensing pad and its analogue oscillator.
`timescale 1ns/100ps
`default_nettype none
module csfm_pad_model (
    // Controls from the block and the bench.
    input wire logic osc_en_i,
    input wire logic drive_i,
    input wire logic noise_i,
    input wire logic loaded_i,
    // Comparator output.
    output logic cmp_o
);
    // Toggles while driven, or at the noise rate when only noise reaches the pad.
    initial begin
        cmp_o = 1'b0;
        forever begin
            if (osc_en_i && (drive_i || noise_i)) begin
                #(drive_i ? (loaded_i ? 280 : 200) : 240);
                cmp_o = ~cmp_o;
            end else begin
                cmp_o = 1'b0;
                @(osc_en_i or drive_i or noise_i);
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/cap_sense_freq_measure_bench.sv
// Bench for mode decode and oscillator count measurements.
`timescale 1ns/100ps
`default_nettype none
module cap_sense_freq_measure_bench;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic sleep_i = 1'b0;
    logic gate_pin = 1'b0;
    logic noise_on = 1'b0;
    logic loaded = 1'b0;
    logic [7:0] reg_rdata_o, v, c_free;
    logic osc_cmp, osc_en, drv_en, noise_det, ref_lo, ref_hi;
    logic [1:0] cur_lvl;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    csfm_top u_csfm_top (.ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .sleep_i, .osc_cmp_i(osc_cmp), .t0_pin_i(1'b0),
        .t1_gate_pin_i(gate_pin), .t1_pin_i(1'b0), .osc_enable_o(osc_en),
        .current_drive_en_o(drv_en), .current_level_o(cur_lvl), .noise_detect_o(noise_det),
        .ref_lo_converter_o(ref_lo), .ref_hi_fixed_reference_o(ref_hi));
    csfm_pad_model u_csfm_pad_model (.osc_en_i(osc_en), .drive_i(drv_en), .noise_i(noise_on),
        .loaded_i(loaded), .cmp_o(osc_cmp));
    initial forever #20 ref_clk_i = ~ref_clk_i;
    // Cuts a hang short.
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            report_and_stop();
        end
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Clears Timer1, lets about 202 cycles pass, then captures the low byte.
    task automatic meas(output logic [7:0] c);
        wr(csfm_pkg::OFS_TMR1_LO, 8'h00);
        wr(csfm_pkg::OFS_TMR1_HI, 8'h00);
        repeat (200) @(posedge ref_clk_i);
        rd(csfm_pkg::OFS_TMR1_LO, c);
    endtask
    // A count within one of its expected figure.
    task automatic near(input logic [7:0] c, input logic [7:0] e);
        chk({7'h00, c + 8'h01 >= e && c <= e + 8'h01}, 8'h01);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        rd(csfm_pkg::OFS_SENSE_CTRL, v);
        chk(v, csfm_pkg::RST_SENSE_CTRL);
        rd(4'hA, v);
        chk(v, 8'h00);
        for (int m = 0; m < 8; m++) begin
            wr(csfm_pkg::OFS_SENSE_CTRL, {1'b1, m[2], 2'b00, m[1:0], 2'b00});
            repeat (2) @(posedge ref_clk_i);
            #1 chk({1'b0, osc_en, drv_en, cur_lvl, noise_det, ref_lo, ref_hi},
                {1'b0, m[2:0] != 0, m[1:0] != 0, m[1:0], m[2:0] == 4, m[2], m[2]});
        end
        wr(csfm_pkg::OFS_TIMER_CFG, 8'h0E);
        noise_on <= 1'b1;
        wr(csfm_pkg::OFS_SENSE_CTRL, 8'hC0);
        meas(v);
        near(v, 8'd16);
        noise_on <= 1'b0;
        wr(csfm_pkg::OFS_SENSE_CTRL, 8'h85);
        meas(c_free);
        near(c_free, 8'd20);
        loaded <= 1'b1;
        meas(v);
        near(v, 8'd14);
        chk({7'h00, v < c_free}, 8'h01);
        loaded <= 1'b0;
        wr(csfm_pkg::OFS_TIMER_CFG, 8'h06);
        meas(v);
        chk(v, 8'h00);
        wr(csfm_pkg::OFS_TIMER_CFG, 8'h1E);
        meas(v);
        chk(v, 8'h00);
        gate_pin <= 1'b1;
        meas(v);
        near(v, 8'd20);
        gate_pin <= 1'b0;
        wr(csfm_pkg::OFS_TIMER_CFG, 8'h00);
        wr(csfm_pkg::OFS_TMR0, 8'h00);
        repeat (198) @(posedge ref_clk_i);
        rd(csfm_pkg::OFS_TMR0, v);
        near(v, 8'd20);
        wr(csfm_pkg::OFS_SENSE_CTRL, 8'h84);
        wr(csfm_pkg::OFS_TIMER_CFG, 8'h7E);
        wr(csfm_pkg::OFS_TMR1_LO, 8'h00);
        wr(csfm_pkg::OFS_TMR0, 8'h00);
        repeat (2100) @(posedge ref_clk_i);
        rd(csfm_pkg::OFS_TMR1_LO, v);
        near(v, 8'd102);
        sleep_i <= 1'b1;
        wr(csfm_pkg::OFS_TIMER_CFG, 8'h0E);
        wr(csfm_pkg::OFS_TMR0, 8'h00);
        meas(v);
        near(v, 8'd20);
        rd(csfm_pkg::OFS_TMR0, v);
        chk(v, 8'h00);
        report_and_stop();
    end
endmodule
bind csfm_top csfm_top_sva u_csfm_top_sva (.ref_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .osc_enable_o, .current_drive_en_o, .current_level_o,
    .noise_detect_o, .ref_lo_converter_o, .ref_hi_fixed_reference_o);
`default_nettype wire
